// *** pmc_defs.svh ***
// Register offsets, reset values and field positions for the port mode configuration block
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_IDX_A_DATA 8'h00
`define PMC_IDX_A_DIR 8'h01
`define PMC_IDX_A_OPT 8'h02
`define PMC_IDX_B_DATA 8'h03
`define PMC_IDX_B_DIR 8'h04
`define PMC_IDX_B_OPT 8'h05
`define PMC_IDX_C_DATA 8'h06
`define PMC_IDX_C_DIR 8'h07
`define PMC_IDX_C_OPT 8'h08
`define PMC_IDX_D_DATA 8'h09
`define PMC_IDX_D_DIR 8'h0A
`define PMC_IDX_D_OPT 8'h0B
`define PMC_IDX_E_DATA 8'h0C
`define PMC_IDX_E_DIR 8'h0D
`define PMC_IDX_E_OPT 8'h0E
`define PMC_IDX_F_DATA 8'h0F
`define PMC_IDX_F_DIR 8'h10
`define PMC_IDX_F_OPT 8'h11
`define PMC_IDX_IRQ_STATUS 8'h12
`define PMC_IDX_IRQ_MASK 8'h13
`define PMC_IDX_CAN_CTRL 8'h14
`define PMC_PORT_RESET 8'h00
`define PMC_CAN_PIN 4
`define PMC_IRQ_BITS 4
`endif

// *** pmc_pkg.sv ***
// Types shared by the port mode configuration block
`default_nettype none
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_FLOAT_IN = 3'b000,
    PMC_PULLUP_IN = 3'b001,
    PMC_OPEN_DRAIN = 3'b010,
    PMC_PUSH_PULL = 3'b011,
    PMC_FLOAT_IRQ = 3'b100,
    PMC_PULLUP_IRQ = 3'b101
  } pmc_mode_t;
endpackage : pmc_pkg
`default_nettype wire

// *** pmc_port_config.sv ***
// APB register bank and pin mode decode for six eight-bit general-purpose ports
// Notes on behaviour
// - Standard pins: 00 float,01 pullup,10 od,11 pp
// - Pulled interrupt pins: 01 is pull-up interrupt
// - Unpulled interrupt pins: 01 is floating interrupt
// - Ports A..D interrupts onto lines 0..3
// - CAN pin never a general output
// - CAN enabled: transmit line drives the pin
// - CAN disabled: pin is pull-up input
// - CAN pin data read returns pin level
// - CAN transmit selected drives push-pull
// - Register bit X maps to pin X
// - Input: read pin, write only latch
// - Output: latch drives pin, read latch
// - Alternate function overrides direction and option
`include "pmc_defs.svh"
`default_nettype none
module pmc_port_config #(
  parameter int NPORT = 6,
  // Interrupt-capable pins per port, pull-up variants and pull-less variants
  parameter logic [7:0] IRQ_PU_A = 8'h55,
  parameter logic [7:0] IRQ_NP_A = 8'hAA,
  parameter logic [7:0] IRQ_PU_B = 8'h15,
  parameter logic [7:0] IRQ_NP_B = 8'h2A,
  parameter logic [7:0] IRQ_PU_C = 8'h02,
  parameter logic [7:0] IRQ_NP_C = 8'h04,
  parameter logic [7:0] IRQ_PU_D = 8'h41,
  parameter logic [7:0] IRQ_NP_D = 8'h92
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [47:0] PIN_IN,
  output logic [47:0] PIN_OUT,
  output logic [47:0] PIN_OE,
  output logic [47:0] PIN_PULLUP,
  input wire logic CAN_TX_LINE,
  output logic EXT_IRQ_LINE_0,
  output logic EXT_IRQ_LINE_1,
  output logic EXT_IRQ_LINE_2,
  output logic EXT_IRQ_LINE_3,
  output logic IRQ
);
  import pmc_pkg::*;

  logic [7:0] latch_reg [NPORT];
  logic [7:0] dir_reg [NPORT];
  logic [7:0] opt_reg [NPORT];
  logic [3:0] irq_status_reg;
  logic [3:0] irq_mask_reg;
  logic can_enable_reg;
  logic [3:0] line_prev_reg;
  logic [3:0] line_now;
  logic [7:0] irq_pu [4];
  logic [7:0] irq_np [4];
  logic [7:0] word_idx;
  logic wr_en;
  logic rd_sel;
  logic addr_ok;
  logic [7:0] rd_byte;
  logic [47:0] pin_out_c;
  logic [47:0] pin_oe_c;
  logic [47:0] pin_pu_c;
  logic [7:0] port_read [NPORT];
  logic [7:0] port_byte;

  // Flattened per-pin views of the port registers and the pin classes
  logic [47:0] dir_flat;
  logic [47:0] opt_flat;
  logic [47:0] latch_flat;
  logic [47:0] class_pu;
  logic [47:0] class_np;
  pmc_mode_t pin_mode [48];
  logic [47:0] irq_in_en;

  // Write strobes, one per register
  logic [NPORT-1:0] wr_latch;
  logic [NPORT-1:0] wr_dir;
  logic [NPORT-1:0] wr_opt;
  logic wr_status;
  logic wr_mask;
  logic wr_can;

  // Interrupt status update terms
  logic [3:0] status_clr;
  logic [3:0] line_rise;

  assign irq_pu[0] = IRQ_PU_A;
  assign irq_pu[1] = IRQ_PU_B;
  assign irq_pu[2] = IRQ_PU_C;
  assign irq_pu[3] = IRQ_PU_D;
  assign irq_np[0] = IRQ_NP_A;
  assign irq_np[1] = IRQ_NP_B;
  assign irq_np[2] = IRQ_NP_C;
  assign irq_np[3] = IRQ_NP_D;

  // Flatten the per-port bytes: pin n is bit n of each vector
  for (genvar gp = 0; gp < NPORT; gp++) begin : g_flat
    assign dir_flat[8 * gp +: 8] = dir_reg[gp];
    assign opt_flat[8 * gp +: 8] = opt_reg[gp];
    assign latch_flat[8 * gp +: 8] = latch_reg[gp];
  end

  // Interrupt-capable pin classes; ports E and F carry standard pins only
  for (genvar gc = 0; gc < 4; gc++) begin : g_class
    assign class_pu[8 * gc +: 8] = irq_pu[gc];
    assign class_np[8 * gc +: 8] = irq_np[gc];
  end
  assign class_pu[47:32] = 16'h0000;
  assign class_np[47:32] = 16'h0000;

  // Word-aligned APB decode; slave answers in the first access cycle
  assign word_idx = {2'b00, PADDR[7:2]};
  assign addr_ok = (PADDR[1:0] == 2'b00) && (word_idx <= `PMC_IDX_CAN_CTRL);
  assign wr_en = PSEL && PENABLE && PWRITE && addr_ok && PSTRB[0];
  assign rd_sel = PSEL && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // One write strobe per port register keeps each register block simple
  always_comb begin
    wr_latch = '0;
    wr_dir = '0;
    wr_opt = '0;
    for (int p = 0; p < NPORT; p++) begin
      wr_latch[p] = wr_en && (word_idx == 8'(3 * p));
      wr_dir[p] = wr_en && (word_idx == 8'(3 * p + 1));
      wr_opt[p] = wr_en && (word_idx == 8'(3 * p + 2));
    end
  end

  // Control register strobes
  assign wr_status = wr_en && (word_idx == `PMC_IDX_IRQ_STATUS);
  assign wr_mask = wr_en && (word_idx == `PMC_IDX_IRQ_MASK);
  assign wr_can = wr_en && (word_idx == `PMC_IDX_CAN_CTRL);

  // Data latches; written in input mode too, only the pin is unaffected
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int p = 0; p < NPORT; p++) begin
        latch_reg[p] <= `PMC_PORT_RESET;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (wr_latch[p]) begin
          latch_reg[p] <= PWDATA[7:0];
        end
      end
    end
  end

  // Direction bits; a one makes the pin an output
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int p = 0; p < NPORT; p++) begin
        dir_reg[p] <= `PMC_PORT_RESET;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (wr_dir[p]) begin
          dir_reg[p] <= PWDATA[7:0];
        end
      end
    end
  end

  // Option bits; their meaning depends on direction and pin class
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      for (int p = 0; p < NPORT; p++) begin
        opt_reg[p] <= `PMC_PORT_RESET;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (wr_opt[p]) begin
          opt_reg[p] <= PWDATA[7:0];
        end
      end
    end
  end

  // CAN alternate function enable
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      can_enable_reg <= 1'b0;
    end else if (wr_can) begin
      can_enable_reg <= PWDATA[0];
    end
  end

  // Per-pin mode from direction, option and pin class
  always_comb begin
    for (int n = 0; n < 48; n++) begin
      case ({dir_flat[n], opt_flat[n]})
        2'b00: begin
          pin_mode[n] = PMC_FLOAT_IN;
        end
        2'b01: begin
          if (class_np[n]) begin
            pin_mode[n] = PMC_FLOAT_IRQ;
          end else if (class_pu[n]) begin
            pin_mode[n] = PMC_PULLUP_IRQ;
          end else begin
            pin_mode[n] = PMC_PULLUP_IN;
          end
        end
        2'b10: begin
          pin_mode[n] = PMC_OPEN_DRAIN;
        end
        2'b11: begin
          pin_mode[n] = PMC_PUSH_PULL;
        end
        default: begin
          pin_mode[n] = PMC_FLOAT_IN;
        end
      endcase
    end
  end

  // Pin drive from the mode; open drain only ever pulls low
  always_comb begin
    pin_out_c = '0;
    pin_oe_c = '0;
    pin_pu_c = '0;
    for (int n = 0; n < 48; n++) begin
      case (pin_mode[n])
        PMC_PULLUP_IN, PMC_PULLUP_IRQ: begin
          pin_pu_c[n] = 1'b1;
        end
        PMC_FLOAT_IN, PMC_FLOAT_IRQ: begin
          pin_pu_c[n] = 1'b0;
        end
        PMC_OPEN_DRAIN: begin
          pin_out_c[n] = latch_flat[n];
          pin_oe_c[n] = !latch_flat[n]; // Released while the latch holds a one
        end
        PMC_PUSH_PULL: begin
          pin_out_c[n] = latch_flat[n];
          pin_oe_c[n] = 1'b1;
        end
        default: begin
          pin_oe_c[n] = 1'b0; // Unused code leaves the pin floating
        end
      endcase
    end
    // CAN pin: transmit line wins over direction and option
    if (can_enable_reg) begin
      pin_out_c[16 + `PMC_CAN_PIN] = CAN_TX_LINE;
      pin_oe_c[16 + `PMC_CAN_PIN] = 1'b1;
      pin_pu_c[16 + `PMC_CAN_PIN] = 1'b0;
    end else begin
      pin_out_c[16 + `PMC_CAN_PIN] = 1'b0;
      pin_oe_c[16 + `PMC_CAN_PIN] = 1'b0;
      pin_pu_c[16 + `PMC_CAN_PIN] = 1'b1;
    end
  end

  // Pin outputs registered so they never glitch on decode changes
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PIN_OUT <= '0;
      PIN_OE <= '0;
      PIN_PULLUP <= '0;
    end else begin
      PIN_OUT <= pin_out_c;
      PIN_OE <= pin_oe_c;
      PIN_PULLUP <= pin_pu_c;
    end
  end

  // Data read value per pin: latch when output, pin level otherwise and always on the CAN pin
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      for (int b = 0; b < 8; b++) begin
        port_read[p][b] = dir_reg[p][b] ? latch_reg[p][b] : PIN_IN[8 * p + b];
      end
    end
    port_read[2][`PMC_CAN_PIN] = PIN_IN[16 + `PMC_CAN_PIN];
  end

  // Only the two interrupt input modes feed a line
  always_comb begin
    for (int n = 0; n < 48; n++) begin
      irq_in_en[n] = (pin_mode[n] == PMC_FLOAT_IRQ)
                     || (pin_mode[n] == PMC_PULLUP_IRQ);
    end
  end

  // Each line ORs the enabled pins of its own port; sensitivity is left outside
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      line_now[p] = |(irq_in_en[8 * p +: 8] & PIN_IN[8 * p +: 8]);
    end
  end
  assign EXT_IRQ_LINE_0 = line_now[0];
  assign EXT_IRQ_LINE_1 = line_now[1];
  assign EXT_IRQ_LINE_2 = line_now[2];
  assign EXT_IRQ_LINE_3 = line_now[3];

  // Edge detector; reset low to match the idle level of the lines
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      line_prev_reg <= 4'h0;
    end else begin
      line_prev_reg <= line_now;
    end
  end

  // Clear request from a write-one-to-clear access, and fresh rising edges
  assign status_clr = wr_status ? PWDATA[3:0] : 4'h0;
  assign line_rise = line_now & ~line_prev_reg;

  // Sticky status; an edge in the same cycle as its clear keeps the bit set
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      irq_status_reg <= 4'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~status_clr) | line_rise;
    end
  end

  // Interrupt mask, a one lets the status bit through
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      irq_mask_reg <= 4'h0;
    end else if (wr_mask) begin
      irq_mask_reg <= PWDATA[3:0];
    end
  end
  assign IRQ = |(irq_status_reg & irq_mask_reg);

  // Port register read byte: data, direction or option of the addressed port
  always_comb begin
    port_byte = 8'h00;
    for (int p = 0; p < NPORT; p++) begin
      if (word_idx == 8'(3 * p)) begin
        port_byte = port_read[p];
      end
      if (word_idx == 8'(3 * p + 1)) begin
        port_byte = dir_reg[p];
      end
      if (word_idx == 8'(3 * p + 2)) begin
        port_byte = opt_reg[p];
      end
    end
  end

  // Control registers sit above the port block; unmapped words read as zero
  always_comb begin
    rd_byte = port_byte;
    if (word_idx == `PMC_IDX_IRQ_STATUS) begin
      rd_byte = {4'h0, irq_status_reg};
    end
    if (word_idx == `PMC_IDX_IRQ_MASK) begin
      rd_byte = {4'h0, irq_mask_reg};
    end
    if (word_idx == `PMC_IDX_CAN_CTRL) begin
      rd_byte = {7'h00, can_enable_reg};
    end
    if (!addr_ok) begin
      rd_byte = 8'h00; // Refused access returns zero alongside the error
    end
  end

  // Read data registered in the setup cycle, valid throughout access
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else if (rd_sel && !PENABLE) begin
      PRDATA <= {24'h000000, rd_byte};
    end
  end
endmodule : pmc_port_config
`default_nettype wire

// *** pmc_port_config_assertions.sv ***
// Concurrent checks on the pin outputs of the port mode configuration block
`default_nettype none
module pmc_port_config_assertions (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic [47:0] PIN_IN,
  input wire logic [47:0] PIN_OUT,
  input wire logic [47:0] PIN_OE,
  input wire logic [47:0] PIN_PULLUP,
  input wire logic CAN_TX_LINE,
  input wire logic EXT_IRQ_LINE_0,
  input wire logic EXT_IRQ_LINE_1,
  input wire logic EXT_IRQ_LINE_2,
  input wire logic EXT_IRQ_LINE_3,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Reserved pin: pulled up unless the transmitter drives it; the first edge still shows reset
  property p_can_pull; $past(RSTN) |-> (PIN_OE[20] || PIN_PULLUP[20]); endproperty
  a_can_pull: assert property (p_can_pull) else $error("can pin floats");
  property p_can_pp; PIN_OE[20] |-> !PIN_PULLUP[20]; endproperty
  a_can_pp: assert property (p_can_pp) else $error("can pin pulled");
  // Driven level follows the transmit line one cycle late
  property p_can_tx;
    $past(RSTN) && PIN_OE[20] |-> PIN_OUT[20] == $past(CAN_TX_LINE);
  endproperty
  a_can_tx: assert property (p_can_tx) else $error("can pin level");
  // Interrupt pins without pull-up never get one
  property p_nopull; (PIN_PULLUP & 48'h0000_9204_2AAA) == 48'h0; endproperty
  a_nopull: assert property (p_nopull) else $error("pull on bare pin");
  // Each line only rises from its own port's interrupt pins
  property p_line0; EXT_IRQ_LINE_0 |-> |PIN_IN[7:0]; endproperty
  a_line0: assert property (p_line0) else $error("line 0 source");
  property p_line1; EXT_IRQ_LINE_1 |-> |PIN_IN[13:8]; endproperty
  a_line1: assert property (p_line1) else $error("line 1 source");
  property p_line2; EXT_IRQ_LINE_2 |-> |PIN_IN[18:17]; endproperty
  a_line2: assert property (p_line2) else $error("line 2 source");
  property p_line3; EXT_IRQ_LINE_3 |-> |{PIN_IN[31:30], PIN_IN[28], PIN_IN[25:24]}; endproperty
  a_line3: assert property (p_line3) else $error("line 3 source");
  c_irq: cover property (IRQ);
  c_line3: cover property (EXT_IRQ_LINE_3);
  c_can: cover property (PIN_OE[20] && PIN_OUT[20]);
endmodule : pmc_port_config_assertions
bind pmc_port_config pmc_port_config_assertions u_chk (.*);
`default_nettype wire

// *** pmc_port_config_tb.sv ***
// Self-checking bench for the port mode configuration block
`default_nettype none
module pmc_port_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic can_tx_line = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] strb = 4'hF;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [47:0] pin_in = 48'h003C_0010_0000;
  logic [47:0] pin_out, pin_oe, pin_pullup;
  logic pready, pslverr, irq;
  wire [3:0] lines;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  pmc_port_config dut (.CLK_SYS(clk_sys), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_PULLUP(pin_pullup), .CAN_TX_LINE(can_tx_line),
    .EXT_IRQ_LINE_0(lines[0]), .EXT_IRQ_LINE_1(lines[1]), .EXT_IRQ_LINE_2(lines[2]),
    .EXT_IRQ_LINE_3(lines[3]), .IRQ(irq));
  always #25 clk_sys = ~clk_sys;
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One transfer held until pready at an edge; x is {pslverr, read data}; pins settle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [32:0] x);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= strb;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    chk({pslverr, w ? 32'h0 : prdata}, x);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : apb
  // Port E: four modes, then latch against pin read-back
  task automatic t_modes;
    apb(1'b0, 8'h38, 8'h00, 33'h0);
    apb(1'b1, 8'h30, 8'hF0, 33'h0);
    apb(1'b1, 8'h38, 8'h0F, 33'h0);
    chk({pin_oe[39:32], pin_pullup[39:32]}, 16'h000F);
    apb(1'b0, 8'h30, 8'h00, 33'h3C);
    apb(1'b1, 8'h34, 8'hFF, 33'h0);
    chk({pin_oe[39:32], pin_out[39:32], pin_pullup[39:32]}, 24'h0FF000);
    apb(1'b0, 8'h30, 8'h00, 33'hF0);
  endtask : t_modes
  // Ports A..D as interrupt inputs, each onto its own line; status and mask
  task automatic t_irq;
    for (int p = 0; p < 4; p++) apb(1'b1, 8'(12 * p + 8), 8'hFF, 33'h0);
    apb(1'b1, 8'h4C, 8'h0F, 33'h0);
    chk(pin_pullup[31:0], 32'h6DFB_D555);
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_sys);
      pin_in[31:0] <= (32'h2 << (8 * p)) | 32'h0010_0000;
      @(negedge clk_sys);
      chk(lines, 4'h1 << p);
    end
    chk(irq, 1'b1);
    apb(1'b1, 8'h4C, 8'h00, 33'h0);
    chk(irq, 1'b0);
    apb(1'b0, 8'h48, 8'h00, 33'h0F);
    apb(1'b1, 8'h48, 8'h0F, 33'h0);
    apb(1'b1, 8'h4C, 8'h0F, 33'h0);
    chk(irq, 1'b0);
    // Port A pins 0 and 1 as push-pull outputs, the rest still interrupt inputs
    apb(1'b1, 8'h04, 8'h03, 33'h0);
    chk({pin_oe[7:0], pin_pullup[7:0]}, 16'h0354);
  endtask : t_irq
  // Reserved pin ignores direction until the transmitter takes it over
  task automatic t_can;
    apb(1'b1, 8'h1C, 8'hFF, 33'h0);
    chk({pin_oe[20], pin_pullup[20]}, 2'b01);
    apb(1'b0, 8'h18, 8'h00, 33'h10);
    apb(1'b1, 8'h50, 8'h01, 33'h0);
    chk({pin_oe[20], pin_out[20], pin_pullup[20]}, 3'b100);
    @(posedge clk_sys);
    can_tx_line <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({pin_oe[20], pin_out[20], pin_pullup[20]}, 3'b110);
    // A write without its low byte strobe must leave the enable standing
    strb = 4'h0;
    apb(1'b1, 8'h50, 8'h00, 33'h0);
    strb = 4'hF;
    apb(1'b0, 8'h50, 8'h00, 33'h01);
    apb(1'b1, 8'h54, 8'hFF, {1'b1, 32'h0});
    apb(1'b0, 8'h31, 8'h00, {1'b1, 32'h0});
  endtask : t_can
  task automatic close_out;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_modes();
    t_irq();
    t_can();
    close_out();
  end
endmodule : pmc_port_config_tb
`default_nettype wire
